// >>> design/twi_engine.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "twi_params.svh"
`default_nettype none
module twi_engine (
	// System
	input wire logic I_SYS_CLK,
	input wire logic I_RSTN,
	// Register port
	input wire logic [3:0] I_ADDR,
	input wire twi_pkg::byte_t I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output var twi_pkg::byte_t O_RDATA,
	// Bus pins
	input wire logic I_SCL,
	output logic O_SCL,
	output logic O_SCL_OE,
	input wire logic I_SDA,
	output logic O_SDA,
	output var logic O_SDA_OE,
	// Interrupt requests
	output logic O_TX_EMPTY_IRQ,
	output logic O_TX_END_IRQ,
	output logic O_RX_FULL_IRQ,
	output logic O_STOP_DET_IRQ,
	output logic O_NACK_IRQ
);
	import twi_pkg::*;

	function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] idx);
		return a == idx;
	endfunction

	function automatic logic out_bit(input byte_t b, input logic lsb_first);
		return lsb_first ? b[0] : b[7];
	endfunction

	logic iface_enable, rx_next_block, master_sel, tx_direction, bus_busy_bit;
	logic [3:0] clk_rate_sel;
	logic bit_order_sel, format_sel, ack_in_value;
	logic [1:0] data_pin_delay_sel;
	logic [6:0] own_addr;
	byte_t irq_enable_reg, bus_status_reg, status_seen;
	byte_t tx_holding_reg, rx_holding_reg, shift_reg;
	byte_t set_vec, clr_vec;
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic [3:0] bit_cnt;
	logic loaded, addr_phase, addressed, halted, rx_armed, ack_latched, sda_bit;
	mstate_t mstate;
	logic [11:0] tmr, half_cnt;
	logic m_scl_low, m_sda_low, s_scl_low, stop_pend;
	logic [2:0] dly_pipe;
	logic sda_low_raw;

	// Register strobes
	logic wr_c1, wr_c2, wr_st, wr_tx, rd_st, rd_rx;
	assign wr_c1 = I_WR && reg_hit(I_ADDR, `TWI_ADDR_CTRL1);
	assign wr_c2 = I_WR && reg_hit(I_ADDR, `TWI_ADDR_CTRL2);
	assign wr_st = I_WR && reg_hit(I_ADDR, `TWI_ADDR_STATUS);
	assign wr_tx = I_WR && reg_hit(I_ADDR, `TWI_ADDR_TXD);
	assign rd_st = I_RD && reg_hit(I_ADDR, `TWI_ADDR_STATUS);
	assign rd_rx = I_RD && reg_hit(I_ADDR, `TWI_ADDR_RXD);

	// Pin sampling; only the second and third stages feed logic
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_d} <= {I_SCL, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {I_SDA, sda_m, sda_s};
		end
	end

	logic scl_rise, scl_fall, start_seen, stop_seen, bus_on;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign bus_on = iface_enable && !format_sel;
	assign start_seen = bus_on && scl_s && scl_d && sda_d && !sda_s;
	assign stop_seen = bus_on && scl_s && scl_d && !sda_d && sda_s;

	// Frame qualifiers
	logic tx_mode, active, ours, do_load, hold_low, rise9, fall_bit, addr_match, arb_lost;
	logic start_req, stop_cmd, slave_to_tx;
	assign tx_mode = tx_direction;
	assign active = bus_on && (master_sel ? (mstate != M_IDLE) : (addr_phase || addressed));
	assign addr_match = addr_phase && !master_sel && (shift_reg[7:1] == own_addr);
	assign ours = master_sel || addressed;
	assign do_load = active && bit_cnt == 4'd0 && !loaded && !scl_s && !halted &&
		(tx_mode ? !bus_status_reg[`TWI_ST_TX_BUF_EMPTY] : (!master_sel || rx_armed));
	assign hold_low = active && ((bit_cnt == 4'd0 && !loaded) || (halted && master_sel) ||
		(ours && !tx_mode && bit_cnt == `TWI_ACK_SLOT &&
		bus_status_reg[`TWI_ST_RX_BUF_FULL]));
	assign rise9 = active && loaded && scl_rise && bit_cnt == `TWI_ACK_SLOT;
	assign fall_bit = active && loaded && scl_fall;
	assign arb_lost = master_sel && active && loaded && scl_rise && bit_cnt < `TWI_ACK_SLOT &&
		tx_mode && sda_bit && !sda_s;
	assign slave_to_tx = rise9 && addr_match && shift_reg[0];
	assign start_req = wr_c2 && I_WDATA[`TWI_C2_BUS_BUSY] && !I_WDATA[`TWI_C2_START_STOP] &&
		master_sel && tx_mode && !bus_busy_bit && mstate == M_IDLE && bus_on;
	assign stop_cmd = wr_c2 && !I_WDATA[`TWI_C2_BUS_BUSY] && !I_WDATA[`TWI_C2_START_STOP] &&
		master_sel && mstate != M_IDLE;
	assign half_cnt = `TWI_HALF_UNIT * {8'h00, clk_rate_sel} + `TWI_HALF_UNIT;

	// Configuration registers
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			irq_enable_reg <= `TWI_RST_BYTE;
			bit_order_sel <= `TWI_RST_BIT;
			own_addr <= 7'h00;
			format_sel <= `TWI_RST_BIT;
			data_pin_delay_sel <= 2'h0;
			tx_holding_reg <= `TWI_RST_BYTE;
		end else if (I_WR) begin
			if (reg_hit(I_ADDR, `TWI_ADDR_IRQ_EN))
				irq_enable_reg <= I_WDATA;
			if (reg_hit(I_ADDR, `TWI_ADDR_MODE))
				bit_order_sel <= I_WDATA[`TWI_MODE_BIT_ORDER];
			if (reg_hit(I_ADDR, `TWI_ADDR_OWN)) begin
				own_addr <= I_WDATA[7:1];
				format_sel <= I_WDATA[`TWI_OWN_FORMAT];
			end
			if (reg_hit(I_ADDR, `TWI_ADDR_PINSEL))
				data_pin_delay_sel <= I_WDATA[1:0];
			if (wr_tx)
				tx_holding_reg <= I_WDATA;
		end
	end

	// Mode bits; hardware updates follow software writes so they win
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			{iface_enable, rx_next_block, master_sel, tx_direction} <= 4'h0;
			clk_rate_sel <= 4'h0;
		end else begin
			if (wr_c1) begin
				iface_enable <= I_WDATA[`TWI_C1_IFACE_EN];
				rx_next_block <= I_WDATA[`TWI_C1_RX_NEXT_BLOCK];
				master_sel <= I_WDATA[`TWI_C1_MASTER];
				tx_direction <= I_WDATA[`TWI_C1_TX_DIR];
				clk_rate_sel <= I_WDATA[3:0];
			end
			if (slave_to_tx)
				tx_direction <= 1'b1;
			if (arb_lost)
				master_sel <= 1'b0;
			if (stop_seen && master_sel) begin
				master_sel <= 1'b0;
				tx_direction <= 1'b0;
			end
		end
	end

	// Bus busy follows bus conditions
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN)
			bus_busy_bit <= `TWI_RST_BIT;
		else if (start_seen)
			bus_busy_bit <= 1'b1;
		else if (stop_seen || !bus_on)
			bus_busy_bit <= 1'b0;
	end

	// Status flags: set wins over clear
	always_comb begin
		set_vec = `TWI_RST_BYTE;
		set_vec[`TWI_ST_TX_BUF_EMPTY] = (do_load && tx_mode) || start_req || slave_to_tx ||
			(wr_c1 && I_WDATA[`TWI_C1_TX_DIR] && !tx_direction);
		set_vec[`TWI_ST_TX_DONE] = rise9 && tx_mode &&
			bus_status_reg[`TWI_ST_TX_BUF_EMPTY];
		set_vec[`TWI_ST_RX_BUF_FULL] = rise9 && !tx_mode && (ours || addr_match);
		set_vec[`TWI_ST_NO_ACK] = rise9 && tx_mode && sda_s && ours &&
			irq_enable_reg[`TWI_IE_ACK_HALT];
		set_vec[`TWI_ST_STOP] = stop_seen;
		set_vec[`TWI_ST_ARB_LOST] = arb_lost;
		set_vec[`TWI_ST_ADDR_MATCH] = rise9 && addr_match;
		clr_vec = wr_st ? (status_seen & ~I_WDATA) : `TWI_RST_BYTE;
		if (wr_tx)
			clr_vec = clr_vec | `TWI_TXD_CLR_MASK;
		if (rd_rx)
			clr_vec = clr_vec | `TWI_RXD_CLR_MASK;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			bus_status_reg <= `TWI_RST_BYTE;
			status_seen <= `TWI_RST_BYTE;
		end else begin
			bus_status_reg <= (bus_status_reg & ~clr_vec) | set_vec;
			if (rd_st)
				status_seen <= bus_status_reg;
			else if (wr_st)
				status_seen <= `TWI_RST_BYTE;
		end
	end

	// Frame engine: bit counting, shifting, acknowledge handling
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN || !bus_on) begin
			bit_cnt <= 4'd0;
			{loaded, addr_phase, addressed, halted, rx_armed} <= 5'h0;
			{ack_latched, ack_in_value} <= 2'h0;
			sda_bit <= 1'b1;
			shift_reg <= `TWI_RST_BYTE;
			rx_holding_reg <= `TWI_RST_BYTE;
		end else begin
			if (rd_rx && master_sel && !tx_mode)
				rx_armed <= 1'b1;
			else if (do_load && !tx_mode && master_sel)
				rx_armed <= 1'b0;
			else if (fall_bit && bit_cnt == `TWI_ACK_SLOT && master_sel && !tx_mode &&
				!rx_next_block)
				rx_armed <= 1'b1;
			if (start_seen || stop_seen) begin
				bit_cnt <= 4'd0;
				{loaded, halted} <= 2'h0;
				addr_phase <= start_seen;
				addressed <= 1'b0;
				sda_bit <= 1'b1;
			end else begin
				if (do_load) begin
					loaded <= 1'b1;
					ack_latched <= irq_enable_reg[`TWI_IE_ACK_OUT];
					if (tx_mode) begin
						shift_reg <= tx_holding_reg;
						sda_bit <= out_bit(tx_holding_reg, bit_order_sel);
					end else
						sda_bit <= 1'b1;
				end
				if (active && loaded && scl_rise) begin
					if (bit_cnt < `TWI_ACK_SLOT)
						shift_reg <= bit_order_sel ? {sda_s, shift_reg[7:1]} :
							{shift_reg[6:0], sda_s};
					else begin
						addr_phase <= 1'b0;
						if (tx_mode)
							ack_in_value <= sda_s;
						if (tx_mode && sda_s && master_sel &&
							irq_enable_reg[`TWI_IE_ACK_HALT])
							halted <= 1'b1;
						if (!tx_mode && (ours || addr_match))
							rx_holding_reg <= shift_reg;
						if (addr_match)
							addressed <= 1'b1;
					end
				end
				if (fall_bit) begin
					if (bit_cnt == `TWI_ACK_SLOT) begin
						bit_cnt <= 4'd0;
						loaded <= 1'b0;
						sda_bit <= 1'b1;
					end else begin
						bit_cnt <= bit_cnt + 4'd1;
						if (bit_cnt == `TWI_ACK_SLOT - 4'd1)
							sda_bit <= tx_mode ? 1'b1 :
								((ours || addr_match) ? ack_latched : 1'b1);
						else
							sda_bit <= tx_mode ? out_bit(shift_reg, bit_order_sel) : 1'b1;
					end
				end
			end
		end
	end

	// Master clock and start/stop sequencer
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN || !bus_on || arb_lost) begin
			mstate <= M_IDLE;
			tmr <= 12'h000;
			{m_scl_low, m_sda_low, stop_pend} <= 3'h0;
		end else begin
			if (stop_cmd)
				stop_pend <= 1'b1;
			case (mstate)
				M_IDLE: begin
					tmr <= 12'h000;
					stop_pend <= 1'b0;
					if (start_req) begin
						m_sda_low <= 1'b1;
						mstate <= M_START;
					end
				end
				M_START: begin
					tmr <= tmr + 12'h001;
					if (tmr == half_cnt) begin
						m_scl_low <= 1'b1;
						// Output register keeps SDA low a cycle after SCL falls
						m_sda_low <= 1'b0;
						tmr <= 12'h000;
						mstate <= M_LOW;
					end
				end
				M_LOW: begin
					if (tmr != half_cnt)
						tmr <= tmr + 12'h001;
					else if ((stop_pend || stop_cmd) && bit_cnt == 4'd0) begin
						m_sda_low <= 1'b1;
						tmr <= 12'h000;
						mstate <= M_STOP_A;
					end else if (hold_low) begin
						// Restart the low half so fresh data settles before SCL rises
						tmr <= 12'h000;
					end else begin
						m_scl_low <= 1'b0;
						tmr <= 12'h000;
						mstate <= M_HIGH;
					end
				end
				M_HIGH: begin
					if (!scl_s)
						tmr <= 12'h000;
					else if (tmr == half_cnt) begin
						m_scl_low <= 1'b1;
						tmr <= 12'h000;
						mstate <= M_LOW;
					end else
						tmr <= tmr + 12'h001;
				end
				M_STOP_A: begin
					tmr <= tmr + 12'h001;
					if (tmr == half_cnt) begin
						m_scl_low <= 1'b0;
						tmr <= 12'h000;
						mstate <= M_STOP_B;
					end
				end
				M_STOP_B: begin
					if (scl_s)
						tmr <= tmr + 12'h001;
					if (tmr == half_cnt) begin
						m_sda_low <= 1'b0;
						mstate <= M_IDLE;
					end
				end
				default: mstate <= M_IDLE;
			endcase
		end
	end

	// Slave stretching only starts once SCL is already low, never cutting a high phase
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN)
			s_scl_low <= 1'b0;
		else
			s_scl_low <= !master_sel && hold_low && (s_scl_low || !scl_s);
	end

	// SDA output delay line
	assign sda_low_raw = (active && loaded && !sda_bit) || m_sda_low;
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			dly_pipe <= 3'h0;
			O_SDA_OE <= 1'b0;
		end else begin
			dly_pipe <= {dly_pipe[1:0], sda_low_raw};
			O_SDA_OE <= (data_pin_delay_sel == 2'h0) ? sda_low_raw :
				dly_pipe[data_pin_delay_sel - 2'h1];
		end
	end

	// Open-drain pins only ever pull low
	assign O_SCL = 1'b0;
	assign O_SDA = 1'b0;
	assign O_SCL_OE = m_scl_low || s_scl_low;

	// Register read port, data in the cycle after the strobe
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN)
			O_RDATA <= `TWI_RST_BYTE;
		else if (I_RD) begin
			case (I_ADDR)
				`TWI_ADDR_CTRL1: O_RDATA <= {iface_enable, rx_next_block, master_sel,
					tx_direction, clk_rate_sel};
				`TWI_ADDR_CTRL2: O_RDATA <= {bus_busy_bit, 5'h00, scl_s, sda_s};
				`TWI_ADDR_MODE: O_RDATA <= {4'h0, bit_order_sel, 3'h0};
				`TWI_ADDR_IRQ_EN: O_RDATA <= {irq_enable_reg[7:2], ack_in_value,
					irq_enable_reg[0]};
				`TWI_ADDR_STATUS: O_RDATA <= bus_status_reg;
				`TWI_ADDR_OWN: O_RDATA <= {own_addr, format_sel};
				`TWI_ADDR_TXD: O_RDATA <= tx_holding_reg;
				`TWI_ADDR_RXD: O_RDATA <= rx_holding_reg;
				`TWI_ADDR_PINSEL: O_RDATA <= {6'h00, data_pin_delay_sel};
				default: O_RDATA <= `TWI_RST_BYTE;
			endcase
		end
	end

	// Interrupt requests on five outputs, each gated by its enable bit; arbitration loss and no-ack share O_NACK_IRQ
	assign O_TX_EMPTY_IRQ = irq_enable_reg[`TWI_IE_TX_EMPTY] &&
		bus_status_reg[`TWI_ST_TX_BUF_EMPTY];
	assign O_TX_END_IRQ = irq_enable_reg[`TWI_IE_TX_END] &&
		bus_status_reg[`TWI_ST_TX_DONE];
	assign O_RX_FULL_IRQ = irq_enable_reg[`TWI_IE_RX_FULL] &&
		bus_status_reg[`TWI_ST_RX_BUF_FULL];
	assign O_STOP_DET_IRQ = !format_sel && irq_enable_reg[`TWI_IE_STOP_DET] &&
		bus_status_reg[`TWI_ST_STOP];
	assign O_NACK_IRQ = irq_enable_reg[`TWI_IE_NACK] && (bus_status_reg[`TWI_ST_ARB_LOST] ||
		(!format_sel && bus_status_reg[`TWI_ST_NO_ACK]));

	AST_TX_WRITE_CLEARS: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		wr_tx && !set_vec[`TWI_ST_TX_DONE] |=> !bus_status_reg[`TWI_ST_TX_DONE])
		else $error("transmit write did not clear done flag");
	AST_RX_READ_CLEARS: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		rd_rx && !set_vec[`TWI_ST_RX_BUF_FULL] |=> !bus_status_reg[`TWI_ST_RX_BUF_FULL])
		else $error("receive read did not clear full flag");
	AST_LOAD_SETS_EMPTY: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		do_load && tx_mode |=> bus_status_reg[`TWI_ST_TX_BUF_EMPTY] && loaded)
		else $error("transfer to shift register did not set empty flag");
	AST_STOP_IRQ_GATED: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		O_STOP_DET_IRQ |-> !format_sel && bus_status_reg[`TWI_ST_STOP])
		else $error("stop request outside bus format");
	AST_NACK_IRQ_SRC: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		bus_status_reg[`TWI_ST_ARB_LOST] && irq_enable_reg[`TWI_IE_NACK] |-> O_NACK_IRQ)
		else $error("arbitration loss did not raise request");
	AST_START_DRIVES_SDA: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		start_req |-> ##[1:5] O_SDA_OE && !O_SCL_OE)
		else $error("start request did not pull SDA low first");
	AST_MASTER_HOLDS_SCL: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		mstate == M_LOW && hold_low && !stop_pend && !stop_cmd |=> O_SCL_OE)
		else $error("master released SCL while waiting");
	AST_RX_STRETCH: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		s_scl_low && !master_sel && !tx_mode && bit_cnt == `TWI_ACK_SLOT && !rd_rx
		|=> O_SCL_OE)
		else $error("slave receiver released SCL while full");
	AST_STOP_TO_SLAVE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		stop_seen && master_sel |=> !master_sel && !tx_direction)
		else $error("master mode kept after stop");
	AST_TX_DONE_NINTH: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		rise9 && tx_mode && bus_status_reg[`TWI_ST_TX_BUF_EMPTY] |=>
		bus_status_reg[`TWI_ST_TX_DONE] && ack_in_value == $past(sda_s))
		else $error("done flag or ack bit missing at ninth rise");
	AST_FLAG_NEEDS_READ: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		wr_st && status_seen == `TWI_RST_BYTE && !wr_tx && !rd_rx
		|=> (bus_status_reg & $past(bus_status_reg)) == $past(bus_status_reg))
		else $error("flag cleared without prior read");
endmodule
`default_nettype wire

// >>> design/twi_params.svh
`ifndef TWI_PARAMS_SVH
`define TWI_PARAMS_SVH
// Register indices
`define TWI_ADDR_CTRL1 4'h0
`define TWI_ADDR_CTRL2 4'h1
`define TWI_ADDR_MODE 4'h2
`define TWI_ADDR_IRQ_EN 4'h3
`define TWI_ADDR_STATUS 4'h4
`define TWI_ADDR_OWN 4'h5
`define TWI_ADDR_TXD 4'h6
`define TWI_ADDR_RXD 4'h7
`define TWI_ADDR_PINSEL 4'h8
// Control register 1 fields, clk_rate_sel in bits 3..0
`define TWI_C1_IFACE_EN 7
`define TWI_C1_RX_NEXT_BLOCK 6
`define TWI_C1_MASTER 5
`define TWI_C1_TX_DIR 4
// Control register 2 fields
`define TWI_C2_BUS_BUSY 7
`define TWI_C2_START_STOP 6
`define TWI_C2_SCL_MON 1
`define TWI_C2_SDA_MON 0
// Mode register field
`define TWI_MODE_BIT_ORDER 3
// Interrupt enable register fields
`define TWI_IE_TX_EMPTY 7
`define TWI_IE_TX_END 6
`define TWI_IE_RX_FULL 5
`define TWI_IE_NACK 4
`define TWI_IE_STOP_DET 3
`define TWI_IE_ACK_HALT 2
`define TWI_IE_ACK_IN 1
`define TWI_IE_ACK_OUT 0
// Status register fields
`define TWI_ST_TX_BUF_EMPTY 7
`define TWI_ST_TX_DONE 6
`define TWI_ST_RX_BUF_FULL 5
`define TWI_ST_NO_ACK 4
`define TWI_ST_STOP 3
`define TWI_ST_ARB_LOST 2
`define TWI_ST_ADDR_MATCH 1
// Own address register field, address in bits 7..1
`define TWI_OWN_FORMAT 0
// Reset values and clear masks
`define TWI_RST_BYTE 8'h00
`define TWI_RST_BIT 1'b0
`define TWI_TXD_CLR_MASK 8'hc0
`define TWI_RXD_CLR_MASK 8'h20
// Timing: half SCL period is this many cycles times (clk_rate_sel + 1)
`define TWI_HALF_UNIT 12'd25
`define TWI_ACK_SLOT 4'd8
`endif

// >>> design/twi_pkg.sv
`default_nettype none
package twi_pkg;
	typedef logic [7:0] byte_t;
	typedef enum {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP_A, M_STOP_B} mstate_t;
endpackage
`default_nettype wire

// >>> testbench/twi_bus_peer.sv
`default_nettype none
module twi_bus_peer (
	// Wire levels
	input wire logic scl,
	input wire logic sda,
	// Behaviour
	input wire logic resp_en,
	input wire logic nack,
	// Open-drain pulls
	output logic scl_oe,
	output logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 200;
	logic [7:0] rx_byte;
	int nbit;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		nbit = 0;
		rx_byte = 8'h00;
	end
	// A start restarts framing
	always @(negedge sda) if (scl && resp_en) nbit = 0;
	always @(posedge scl) if (resp_en && nbit < 8) begin
		rx_byte = {rx_byte[6:0], sda};
		nbit++;
	end
	// Ack slot is the ninth clock; released lines float to the pull-up
	always @(negedge scl) if (resp_en) begin
		if (nbit == 8) begin
			sda_oe <= !nack;
			nbit = 9;
		end else if (nbit == 9) begin
			sda_oe <= 1'b0;
			nbit = 0;
		end
	end
	// Bounded wait, since the engine may stretch the low phase
	task automatic wait_high();
		scl_oe = 1'b0;
		for (int i = 0; i < 400 && !scl; i++) #50;
		#HALF;
	endtask
	task automatic send_start();
		sda_oe = 1'b1;
		#HALF;
		scl_oe = 1'b1;
		#HALF;
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_oe = !b[i];
			#HALF;
			wait_high();
			scl_oe = 1'b1;
		end
		sda_oe = 1'b0;
		#HALF;
		wait_high();
		ack = sda;
		scl_oe = 1'b1;
	endtask
	task automatic release_scl();
		scl_oe = 1'b0;
	endtask
	task automatic send_stop();
		sda_oe = 1'b1;
		#HALF;
		wait_high();
		sda_oe = 1'b0;
		#HALF;
	endtask
endmodule
`default_nettype wire

// >>> testbench/twi_engine_tb.sv
`include "twi_params.svh"
`default_nettype none
module twi_engine_tb;
	import twi_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] ST = `TWI_ADDR_STATUS;
	localparam logic [3:0] IE = `TWI_ADDR_IRQ_EN;
	logic I_SYS_CLK, I_RSTN, I_WR, I_RD, resp_en, nack;
	logic scl_oe, sda_oe, p_scl_oe, p_sda_oe;
	logic [3:0] I_ADDR;
	byte_t I_WDATA, rdata;
	logic [4:0] irq;
	wire logic scl;
	wire logic sda;
	int mismatches, n_tests;
	assign scl = !(scl_oe || p_scl_oe);
	assign sda = !(sda_oe || p_sda_oe);
	twi_engine twi_engine_i (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR),
		.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(rdata), .I_SCL(scl),
		.O_SCL(), .O_SCL_OE(scl_oe), .I_SDA(sda), .O_SDA(), .O_SDA_OE(sda_oe),
		.O_TX_EMPTY_IRQ(irq[4]), .O_TX_END_IRQ(irq[3]), .O_RX_FULL_IRQ(irq[2]),
		.O_STOP_DET_IRQ(irq[1]), .O_NACK_IRQ(irq[0]));
	twi_bus_peer peer_i (.scl(scl), .sda(sda), .resp_en(resp_en), .nack(nack),
		.scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
	initial begin
		I_SYS_CLK = 1'b0;
		forever #25 I_SYS_CLK = !I_SYS_CLK;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input byte_t d);
		@(posedge I_SYS_CLK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_SYS_CLK);
		I_WR <= 1'b0;
		@(negedge I_SYS_CLK);
	endtask
	task automatic rd(input logic [3:0] a, output byte_t d);
		@(posedge I_SYS_CLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_SYS_CLK);
		I_RD <= 1'b0;
		@(negedge I_SYS_CLK);
		d = rdata;
	endtask
	task automatic wait_st(input int b);
		byte_t s;
		s = 8'h00;
		for (int i = 0; i < 2000 && s[b] !== 1'b1; i++) rd(ST, s);
		chk("status wait", 8'h01, {7'h00, s[b]});
	endtask
	task automatic t_reset();
		byte_t s;
		rd(ST, s);
		chk("status rst", 8'h00, s);
		rd(4'h9, s);
		chk("unmapped", 8'h00, s);
		chk("irq rst", 8'h00, {3'h0, irq});
	endtask
	task automatic t_master_tx();
		byte_t s;
		wr(IE, 8'hc0);
		wr(`TWI_ADDR_CTRL1, 8'hb0);
		chk("tx empty irq", 8'h10, {3'h0, irq} & 8'h10);
		wr(`TWI_ADDR_CTRL2, 8'h80);
		wr(`TWI_ADDR_TXD, 8'ha4);
		wait_st(`TWI_ST_TX_DONE);
		chk("addr byte", 8'ha4, peer_i.rx_byte);
		repeat (200) @(posedge I_SYS_CLK);
		chk("scl held", 8'h00, {7'h00, scl});
		chk("tx end irq", 8'h08, {3'h0, irq} & 8'h08);
		rd(IE, s);
		chk("ack in", 8'h00, s & 8'h02);
		wr(`TWI_ADDR_TXD, 8'h5a);
		rd(ST, s);
		chk("done clr", 8'h00, s & 8'h40);
		wait_st(`TWI_ST_TX_DONE);
		chk("data byte", 8'h5a, peer_i.rx_byte);
		wr(`TWI_ADDR_CTRL2, 8'h00);
		wait_st(`TWI_ST_STOP);
		rd(`TWI_ADDR_CTRL1, s);
		chk("slave rx", 8'h00, s & 8'h30);
		wr(IE, 8'h08);
		chk("stop irq", 8'h02, {3'h0, irq} & 8'h02);
		wr(ST, 8'hff);
		wr(ST, 8'h00);
		rd(ST, s);
		chk("stop kept", 8'h08, s & 8'h08);
		wr(ST, 8'h00);
		rd(ST, s);
		chk("stop clr", 8'h00, s & 8'h08);
	endtask
	task automatic t_nack();
		byte_t s;
		nack = 1'b1;
		wr(IE, 8'h14);
		wr(`TWI_ADDR_PINSEL, 8'h03);
		wr(`TWI_ADDR_MODE, 8'h08);
		wr(`TWI_ADDR_CTRL1, 8'hb1);
		wr(`TWI_ADDR_CTRL2, 8'h80);
		wr(`TWI_ADDR_TXD, 8'h12);
		wait_st(`TWI_ST_NO_ACK);
		chk("lsb byte", 8'h48, peer_i.rx_byte);
		chk("nack irq", 8'h01, {3'h0, irq} & 8'h01);
		rd(IE, s);
		chk("ack in 1", 8'h02, s & 8'h02);
		wr(`TWI_ADDR_CTRL2, 8'h00);
		wait_st(`TWI_ST_STOP);
		wr(ST, 8'h00);
		wr(`TWI_ADDR_PINSEL, 8'h00);
		wr(`TWI_ADDR_MODE, 8'h00);
		nack = 1'b0;
	endtask
	task automatic t_slave_rx();
		byte_t s;
		logic a;
		resp_en = 1'b0;
		wr(`TWI_ADDR_OWN, 8'ha4);
		wr(`TWI_ADDR_CTRL1, 8'h80);
		wr(IE, 8'h20);
		peer_i.send_start();
		peer_i.send_byte(8'ha4, a);
		chk("addr ack", 8'h00, {7'h00, a});
		rd(ST, s);
		chk("addressed", 8'h22, s & 8'h22);
		chk("rx irq", 8'h04, {3'h0, irq} & 8'h04);
		rd(`TWI_ADDR_RXD, s);
		chk("rx addr", 8'ha4, s);
		rd(ST, s);
		chk("full clr", 8'h00, s & 8'h20);
		peer_i.send_byte(8'h3c, a);
		chk("data ack", 8'h00, {7'h00, a});
		rd(`TWI_ADDR_RXD, s);
		chk("rx data", 8'h3c, s);
		peer_i.send_stop();
	endtask
	task automatic t_slave_tx();
		byte_t s;
		logic a;
		peer_i.send_start();
		peer_i.send_byte(8'ha5, a);
		chk("rd addr ack", 8'h00, {7'h00, a});
		rd(ST, s);
		chk("slave tx empty", 8'h80, s & 8'h80);
		rd(`TWI_ADDR_CTRL1, s);
		chk("slave tx dir", 8'h10, s & 8'h10);
		peer_i.release_scl();
		repeat (20) @(posedge I_SYS_CLK);
		chk("slave stretch", 8'h00, {7'h00, scl});
		wr(`TWI_ADDR_CTRL1, 8'h80);
		rd(`TWI_ADDR_RXD, s);
		repeat (20) @(posedge I_SYS_CLK);
		chk("scl freed", 8'h01, {7'h00, scl});
		peer_i.send_stop();
	endtask
	task automatic results();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#3000000;
		mismatches++;
		results();
	end
	initial begin
		I_RSTN = 1'b0;
		I_WR = 1'b0;
		I_RD = 1'b0;
		I_ADDR = 4'h0;
		I_WDATA = 8'h00;
		resp_en = 1'b1;
		nack = 1'b0;
		mismatches = 0;
		n_tests = 0;
		repeat (6) @(posedge I_SYS_CLK);
		I_RSTN <= 1'b1;
		t_reset();
		t_master_tx();
		t_nack();
		t_slave_rx();
		t_slave_tx();
		results();
	end
endmodule
`default_nettype wire
